// >>> logic/one_shot_consts.vh
// Purpose: Shared constants for the two-input one-shot pulse timer
// Assumes: Word-indexed register port, 16-bit data
// Notes:   Offsets are register indices on the plain register port
`ifndef ONE_SHOT_CONSTS_VH
`define ONE_SHOT_CONSTS_VH

// Counter, data and address widths of the 16-bit product
`define DATA_W            16
`define ADDR_W            4

// Register indices
`define REG_CHAN_CTRL     4'h0
`define REG_MASTER_MODE   4'h1
`define REG_SLAVE_MODE    4'h2
`define REG_MASTER_DELAY  4'h3
`define REG_SLAVE_CAPTURE 4'h4
`define REG_MASTER_COUNT  4'h5
`define REG_SLAVE_COUNT   4'h6
`define REG_SLAVE_STATUS  4'h7
`define REG_OUTPUT_CTRL   4'h8
`define REG_PRESCALER     4'h9
`define REG_PERIPH_EN     4'hA

// Channel control fields (write: trigger bits, read: enable status)
`define CTRL_MASTER_START 0
`define CTRL_SLAVE_START  1
`define CTRL_MASTER_STOP  2
`define CTRL_SLAVE_STOP   3

// Channel mode fields
`define MODE_EDGE_LSB     0
`define MODE_EDGE_MSB     1
`define MODE_CLK_SEL      2

// Output control fields
`define OUT_ENABLE        0
`define OUT_POLARITY      1
`define OUT_SW_LEVEL      2
`define OUT_MODE_MASTER   3
`define OUT_MODE_SLAVE    4
`define OUT_SW_MASTER     5

// Prescaler fields
`define PRE_A_LSB         0
`define PRE_A_MSB         3
`define PRE_B_LSB         4
`define PRE_B_MSB         7

// Status fields
`define STATUS_OVERFLOW   0

// Edge select codes
`define EDGE_FALLING      2'h0
`define EDGE_RISING       2'h1
`define EDGE_BOTH         2'h2

// Counter values
`define COUNT_ZERO        16'h0000
`define COUNT_FULL        16'hFFFF

`endif

// >>> logic/trigger_edge_detect.v
// Purpose: Synchronise a trigger pin and detect its valid edge
// Assumes: Sample strobe is one clk wide at the operating clock rate
// Notes:   Edge reported only in the clk after a sample strobe
`timescale 1ns/100ps
`default_nettype none
`include "one_shot_consts.vh"

module trigger_edge_detect (
  input  wire       clk,
  input  wire       rst_sync_b,
  input  wire       pin,
  input  wire       sample,
  input  wire [1:0] edge_select,
  output wire       valid_edge
);

  reg sync_a;
  reg sync_b;
  reg sampled;
  reg prev;

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      sampled <= 1'b0;
      prev    <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      if (sample) begin
        sampled <= sync_b;
        prev    <= sampled;
      end
    end
  end

  wire rise = sampled & ~prev;
  wire fall = ~sampled & prev;

  // One clk after the sample strobe, once prev and sampled have updated
  reg pend;
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pend <= 1'b0;
    end else begin
      pend <= sample;
    end
  end

  assign valid_edge = pend & ((edge_select == `EDGE_FALLING) ? fall :
                              (edge_select == `EDGE_RISING)  ? rise :
                              (rise | fall));

endmodule // trigger_edge_detect
`default_nettype wire

// >>> logic/two_input_one_shot_pulse_timer.v
// Purpose: Two-channel input timer making a delayed one-shot pulse
// Assumes: Master channel and slave channel 3 of a 16-bit timer array unit
// Notes:   Count clock is the selected prescaled operating clock
//
// Notes on behaviour
// - Output delay is master delay value plus 2 count clock periods.
// - Pulse width is captured value plus 1, plus 10000H on overflow.
// - Both trigger pins are sampled with the selected operating clock.
// - Only 16-bit; master is channel 0 or 2, slave channel 3.
// - Start edge loads master delay into master counter, counting down.
// - At 0000H master raises interrupt, awaits trigger; pulse goes active one count clock later.
// - After expiry master counter holds FFFFH until a new start.
// - End edge captures slave count, clears counter, interrupts, goes inactive.
// - Master expiry clears slave counter, which then counts up.
// - Each capture sets overflow flag if counter wrapped, else clears it.
// - Two or more wraps also set the overflow flag.
// - Software master start bit acts as a start trigger while the master is enabled.
// - Stop self-clears, clears enables; counters and output hold.
// - Slave counter, capture, status and master counter readable whenever the unit is enabled.
// - Peripheral enable low stops clock, blocks access, resets registers.
// - Output enable high: events drive pin; low: software level shown.
// - Slave polarity bit: 0 active-high, 1 active-low.
// - Clock select picks prescaled clock a or b; slave follows master.
// - While stopped, output writes that keep enable high and keep polarity do not change the pin.
`timescale 1ns/100ps
`default_nettype none
`include "one_shot_consts.vh"

module two_input_one_shot_pulse_timer #(
  parameter MASTER_CHANNEL = 0
) (
  input  wire                 clk,
  input  wire                 rst_b,
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [`DATA_W-1:0]   wdata,
  input  wire                 wr,
  input  wire                 rd,
  output reg  [`DATA_W-1:0]   rdata,
  input  wire                 start_trigger_input,
  input  wire                 end_trigger_input,
  output reg                  pulse_output_pin,
  output reg                  master_output_pin,
  output reg                  master_expiry_irq,
  output reg                  slave_capture_irq
);

  // Master sequence states
  localparam ST_STOPPED = 2'h0;
  localparam ST_WAIT    = 2'h1;
  localparam ST_COUNT   = 2'h2;

  // Reset release
  reg rst_meta_b;
  reg rst_sync_b;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Prescaler tick: every 2**sel clk cycles
  function prescale_tick;
    input [`DATA_W-1:0] cnt;
    input [3:0]         sel;
    reg   [`DATA_W-1:0] mask;
    begin
      mask = (16'h0001 << sel) - 16'h0001;
      prescale_tick = ((cnt & mask) == mask);
    end
  endfunction

  reg                  unit_clock_gate_bit;
  reg  [`DATA_W-1:0]   prescaler_count;
  reg  [7:0]           prescaler_select_reg;
  reg  [2:0]           master_mode_reg;
  reg  [1:0]           slave_edge_select;
  reg  [`DATA_W-1:0]   master_delay_value;
  reg  [`DATA_W-1:0]   slave_capture_value;
  reg  [`DATA_W-1:0]   master_counter;
  reg  [`DATA_W-1:0]   slave_counter;
  reg                  overflow_flag;
  reg                  overflow_seen;
  reg  [1:0]           channel_enable_status;
  reg  [5:0]           output_ctrl;
  reg  [1:0]           master_state;
  reg                  slave_armed;
  reg                  slave_active_pend;
  reg                  pulse_active;

  // Unit disabled: writes and reads other than the peripheral enable are refused
  wire wr_ok = wr & unit_clock_gate_bit;
  wire rd_ok = rd & unit_clock_gate_bit;

  wire prescaled_clock_a = prescale_tick(prescaler_count,
    prescaler_select_reg[`PRE_A_MSB:`PRE_A_LSB]);
  wire prescaled_clock_b = prescale_tick(prescaler_count,
    prescaler_select_reg[`PRE_B_MSB:`PRE_B_LSB]);
  wire channel_clock_select = master_mode_reg[`MODE_CLK_SEL];
  // Slave shares the master's operating clock
  wire count_tick = unit_clock_gate_bit &
    (channel_clock_select ? prescaled_clock_b : prescaled_clock_a);

  wire start_edge;
  wire end_edge;

  trigger_edge_detect start_detect (
    .clk         (clk),
    .rst_sync_b  (rst_sync_b),
    .pin         (start_trigger_input),
    .sample      (count_tick),
    .edge_select (master_mode_reg[`MODE_EDGE_MSB:`MODE_EDGE_LSB]),
    .valid_edge  (start_edge)
  );

  trigger_edge_detect end_detect (
    .clk         (clk),
    .rst_sync_b  (rst_sync_b),
    .pin         (end_trigger_input),
    .sample      (count_tick),
    .edge_select (slave_edge_select),
    .valid_edge  (end_edge)
  );

  wire ctrl_wr     = wr_ok & (addr == `REG_CHAN_CTRL);
  wire sw_start_m  = ctrl_wr & wdata[`CTRL_MASTER_START];
  wire sw_start_s  = ctrl_wr & wdata[`CTRL_SLAVE_START];
  wire sw_stop_m   = ctrl_wr & wdata[`CTRL_MASTER_STOP];
  wire sw_stop_s   = ctrl_wr & wdata[`CTRL_SLAVE_STOP];
  wire master_run  = channel_enable_status[0];
  wire slave_run   = channel_enable_status[1];
  // Software start while already enabled counts as a start trigger
  wire master_trig = master_run & (start_edge | sw_start_m);
  // Expiry happens only on a count tick
  wire master_fire = master_run & (master_state == ST_COUNT) & count_tick &
                     (master_counter == `COUNT_ZERO);
  wire slave_capture = slave_run & slave_armed & end_edge;

  // Prescaler and peripheral enable
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      unit_clock_gate_bit <= 1'b0;
      prescaler_count     <= 16'h0000;
    end else begin
      if (wr && addr == `REG_PERIPH_EN) begin
        unit_clock_gate_bit <= wdata[0];
      end
      if (unit_clock_gate_bit) begin
        prescaler_count <= prescaler_count + 16'h0001;
      end else begin
        prescaler_count <= 16'h0000;
      end
    end
  end

  // Software-written configuration
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prescaler_select_reg <= 8'h00;
      master_mode_reg      <= 3'h0;
      slave_edge_select    <= 2'h0;
      master_delay_value   <= 16'h0000;
      output_ctrl          <= 6'h00;
    end else if (!unit_clock_gate_bit) begin
      prescaler_select_reg <= 8'h00;
      master_mode_reg      <= 3'h0;
      slave_edge_select    <= 2'h0;
      master_delay_value   <= 16'h0000;
      output_ctrl          <= 6'h00;
    end else if (wr_ok) begin
      case (addr)
        `REG_PRESCALER:    prescaler_select_reg <= wdata[7:0];
        `REG_MASTER_MODE:  master_mode_reg      <= wdata[2:0];
        `REG_SLAVE_MODE:   slave_edge_select    <= wdata[`MODE_EDGE_MSB:`MODE_EDGE_LSB];
        `REG_MASTER_DELAY: master_delay_value   <= wdata;
        `REG_OUTPUT_CTRL:  output_ctrl          <= wdata[5:0];
        default: begin
        end
      endcase
    end
  end

  // Channel enables and master sequence
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      channel_enable_status <= 2'h0;
      master_state          <= ST_STOPPED;
      master_counter        <= 16'h0000;
      master_expiry_irq     <= 1'b0;
    end else if (!unit_clock_gate_bit) begin
      channel_enable_status <= 2'h0;
      master_state          <= ST_STOPPED;
      master_counter        <= 16'h0000;
      master_expiry_irq     <= 1'b0;
    end else begin
      master_expiry_irq <= master_fire;
      // Start wins over stop in the enable bits when both are written; a waiting or counting master still stops
      if (sw_start_m) begin
        channel_enable_status[0] <= 1'b1;
      end else if (sw_stop_m) begin
        channel_enable_status[0] <= 1'b0;
      end
      if (sw_start_s) begin
        channel_enable_status[1] <= 1'b1;
      end else if (sw_stop_s) begin
        channel_enable_status[1] <= 1'b0;
      end
      case (master_state)
        ST_STOPPED: begin
          if (sw_start_m) begin
            master_state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (sw_stop_m) begin
            master_state <= ST_STOPPED;
          end else if (master_trig) begin
            master_counter <= master_delay_value;
            master_state   <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (sw_stop_m) begin
            master_state <= ST_STOPPED;
          end else if (master_trig) begin
            master_counter <= master_delay_value;
          end else if (master_fire) begin
            master_counter <= `COUNT_FULL;
            master_state   <= ST_WAIT;
          end else if (count_tick) begin
            master_counter <= master_counter - 16'h0001;
          end
        end
        default: begin
          master_state <= ST_STOPPED;
        end
      endcase
    end
  end

  // Slave capture channel
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      slave_counter       <= 16'h0000;
      slave_capture_value <= 16'h0000;
      overflow_flag       <= 1'b0;
      overflow_seen       <= 1'b0;
      slave_armed         <= 1'b0;
      slave_active_pend   <= 1'b0;
      pulse_active        <= 1'b0;
      slave_capture_irq   <= 1'b0;
    end else if (!unit_clock_gate_bit) begin
      slave_counter       <= 16'h0000;
      slave_capture_value <= 16'h0000;
      overflow_flag       <= 1'b0;
      overflow_seen       <= 1'b0;
      slave_armed         <= 1'b0;
      slave_active_pend   <= 1'b0;
      pulse_active        <= 1'b0;
      slave_capture_irq   <= 1'b0;
    end else begin
      slave_capture_irq <= slave_capture;
      if (slave_run) begin
        // Capture wins over a same-cycle expiry
        if (slave_capture) begin
          slave_capture_value <= slave_counter;
          slave_counter       <= `COUNT_ZERO;
          overflow_flag       <= overflow_seen;
          overflow_seen       <= 1'b0;
          slave_armed         <= 1'b0;
          slave_active_pend   <= 1'b0;
          pulse_active        <= 1'b0;
        end else if (master_fire) begin
          slave_counter     <= `COUNT_ZERO;
          overflow_seen     <= 1'b0;
          slave_armed       <= 1'b1;
          slave_active_pend <= 1'b1;
        end else if (count_tick && slave_active_pend) begin
          // Active one count clock after the master interrupt
          slave_active_pend <= 1'b0;
          pulse_active      <= 1'b1;
        end else if (count_tick && slave_armed) begin
          slave_counter <= slave_counter + 16'h0001;
          if (slave_counter == `COUNT_FULL) begin
            overflow_seen <= 1'b1;
          end
        end
      end
    end
  end

  // Pin drive: event level or software level
  wire output_enable_bit   = output_ctrl[`OUT_ENABLE];
  wire output_polarity_bit = output_ctrl[`OUT_POLARITY];
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pulse_output_pin  <= 1'b0;
      master_output_pin <= 1'b0;
    end else begin
      // Master polarity has no effect in master output mode
      master_output_pin <= output_ctrl[`OUT_SW_MASTER];
      if (output_enable_bit) begin
        // Stopped channels raise no events, so the level holds
        pulse_output_pin <= pulse_active ^ output_polarity_bit;
      end else begin
        pulse_output_pin <= output_ctrl[`OUT_SW_LEVEL];
      end
    end
  end

  // Read port, data one cycle after the strobe
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata <= 16'h0000;
    end else if (rd && addr == `REG_PERIPH_EN) begin
      rdata <= {15'h0000, unit_clock_gate_bit};
    end else if (rd_ok) begin
      case (addr)
        `REG_CHAN_CTRL:     rdata <= {14'h0000, channel_enable_status};
        `REG_MASTER_MODE:   rdata <= {13'h0000, master_mode_reg};
        `REG_SLAVE_MODE:    rdata <= {13'h0000, channel_clock_select, slave_edge_select};
        `REG_MASTER_DELAY:  rdata <= master_delay_value;
        `REG_SLAVE_CAPTURE: rdata <= slave_capture_value;
        `REG_MASTER_COUNT:  rdata <= master_counter;
        `REG_SLAVE_COUNT:   rdata <= slave_counter;
        `REG_SLAVE_STATUS:  rdata <= {15'h0000, overflow_flag};
        `REG_OUTPUT_CTRL:   rdata <= {10'h000, output_ctrl};
        `REG_PRESCALER:     rdata <= {8'h00, prescaler_select_reg};
        default:            rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule // two_input_one_shot_pulse_timer
`default_nettype wire

// >>> tb/trigger_source.sv
// Purpose: Far-side model making start and end trigger edges
// Assumes: Pulse width counted in clk cycles while the pin is active
// Notes:   Only rising edges matter; start falls as end rises, end falls once the pulse ends
`timescale 1ns/100ps
`default_nettype none

module trigger_source (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [19:0] width,
  input  wire logic        act,
  input  wire logic        pulse,
  output var  logic        start_trig,
  output var  logic        end_trig
);
  logic [19:0] cnt;

  initial begin
    start_trig = 1'b0;
    end_trig   = 1'b0;
    cnt        = 20'h00000;
  end

  // Start edge on request, end edge after the asked width
  always @(posedge clk) begin
    if (go) begin
      start_trig <= 1'b1;
      cnt        <= 20'h00000;
    end else if (start_trig && pulse === act) begin
      cnt <= cnt + 20'h00001;
      if (cnt == width) begin
        start_trig <= 1'b0;
        end_trig   <= 1'b1;
      end
    end else if (end_trig && pulse !== act) begin
      end_trig <= 1'b0;
    end
  end
endmodule // trigger_source

`default_nettype wire

// >>> tb/two_input_one_shot_pulse_timer_chk.sv
// Purpose: Port-level checker for the one-shot pulse timer
// Assumes: Register writes shadowed from the plain register port
// Notes:   Bound to the top module
`timescale 1ns/100ps
`default_nettype none

module two_input_one_shot_pulse_timer_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        pulse_output_pin,
  input wire logic        master_output_pin,
  input wire logic        master_expiry_irq,
  input wire logic        slave_capture_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic       en, oe, pol, swl, msw, run, armed, drd;
  logic [2:0] qcnt, wcnt;
  logic       csel;
  logic [7:0] pre;
  logic [3:0] psel;

  // Prescaler select of the chosen count clock
  assign psel = csel ? pre[7:4] : pre[3:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {en, oe, pol, swl, msw, run, armed, drd} <= 8'h00;
      qcnt <= 3'h0;
      wcnt <= 3'h0;
      csel <= 1'b0;
      pre  <= 8'h00;
    end else begin
      drd <= rd && !en && addr != 4'hA;
      if (en && wr && addr == 4'h8) {msw, swl, pol, oe} <= {wdata[5], wdata[2:0]};
      if (en && wr && addr == 4'h0) run <= wdata[0] | (run & ~wdata[2]);
      if (en && wr && addr == 4'h9) pre <= wdata[7:0];
      if (en && wr && addr == 4'h1) csel <= wdata[2];
      if (master_expiry_irq) armed <= 1'b1;
      if (slave_capture_irq) armed <= 1'b0;
      if (wr && addr == 4'hA) begin
        en <= wdata[0];
        if (!wdata[0]) {oe, pol, swl, msw, run, armed, csel, pre} <= 14'h0000;
      end
      wcnt <= (wr && (addr == 4'h8 || addr == 4'hA)) ? 3'h0 :
              (wcnt == 3'h7) ? wcnt : wcnt + 3'h1;
      qcnt <= (run || !oe || (wr && addr == 4'h8 && wdata[1:0] != {pol, oe})) ? 3'h0 :
              (qcnt == 3'h7) ? qcnt : qcnt + 3'h1;
    end
  end

  a_expiry_single: assert property (master_expiry_irq |=> !master_expiry_irq)
    else $error("expiry interrupt longer than one cycle");
  a_capture_single: assert property (slave_capture_irq |=> !slave_capture_irq)
    else $error("capture interrupt longer than one cycle");
  a_capture_after_expiry: assert property (slave_capture_irq |-> armed)
    else $error("capture without a preceding expiry");
  a_expiry_activates: assert property (
    master_expiry_irq && oe && run && psel == 4'h0 |-> ##2 pulse_output_pin == !pol)
    else $error("pulse not active two cycles after expiry");
  a_slow_activate: assert property (
    master_expiry_irq && oe && run && psel == 4'h1 |-> ##3 pulse_output_pin == !pol)
    else $error("pulse not active one slow count clock after expiry");
  a_capture_releases: assert property (
    slave_capture_irq && oe |-> ##[0:2] pulse_output_pin == pol)
    else $error("pulse not inactive after capture");
  a_stopped_pin_holds: assert property (qcnt >= 3'h4 |-> $stable(pulse_output_pin))
    else $error("pulse pin moved while stopped");
  a_sw_level_shown: assert property (
    en && !oe && wcnt >= 3'h3 |-> pulse_output_pin == swl)
    else $error("pulse pin differs from software level");
  a_master_level: assert property (en && wcnt >= 3'h3 |-> master_output_pin == msw)
    else $error("master pin differs from software level");
  a_rdata_one_cycle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_disabled_read_zero: assert property (drd |-> rdata == 16'h0000)
    else $error("read data while unit disabled");
endmodule // two_input_one_shot_pulse_timer_chk

bind two_input_one_shot_pulse_timer two_input_one_shot_pulse_timer_chk chk_u (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .pulse_output_pin(pulse_output_pin),
  .master_output_pin(master_output_pin), .master_expiry_irq(master_expiry_irq),
  .slave_capture_irq(slave_capture_irq));

`default_nettype wire

// >>> tb/two_input_one_shot_pulse_timer_test.sv
// Purpose: Self-checking bench for the one-shot pulse timer
// Assumes: Prescaler select 0 except the clock b scenario at half rate
// Notes:   Settings change only while the channels are stopped
`timescale 1ns/100ps
`default_nettype none

module two_input_one_shot_pulse_timer_test;
  logic        clk, rst_b, wr, rd, go, act, st_in, end_in, pin, mpin, mirq, sirq;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, v, cap;
  logic [19:0] width;
  int          error_cnt, checked, n, nd [2];

  always #12.5 clk = ~clk;

  two_input_one_shot_pulse_timer dut_u (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .start_trigger_input(st_in), .end_trigger_input(end_in),
    .pulse_output_pin(pin), .master_output_pin(mpin),
    .master_expiry_irq(mirq), .slave_capture_irq(sirq));

  trigger_source partner_u (
    .clk(clk), .go(go), .width(width), .act(act), .pulse(pin),
    .start_trig(st_in), .end_trig(end_in));

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic wait_for(input logic on_pin, input logic lvl, output int cnt);
    cnt = 0;
    while ((on_pin ? pin : mirq) !== lvl) begin
      @(posedge clk);
      cnt++;
      if (cnt > 80000) begin
        error_cnt++;
        end_sim();
      end
    end
  endtask

  task automatic t_access();
    rd_reg(4'h8, v); chk(v, 0);
    wr_reg(4'h3, 16'h0005);
    wr_reg(4'hA, 16'h0001);
    rd_reg(4'h3, v); chk(v, 0);
    rd_reg(4'hF, v); chk(v, 0);
    rd_reg(4'h0, v); chk(v, 0);
    wr_reg(4'h9, 16'h0000);
    wr_reg(4'h1, 16'h0001);
    wr_reg(4'h2, 16'h0001);
  endtask

  // Pin-started pulses: polarity, plain width and counter wrap
  task automatic t_pulses();
    logic        pol [3] = '{1'b1, 1'b0, 1'b0};
    logic [19:0] w [3]   = '{20'd30, 20'd65600, 20'd5};
    for (int i = 0; i < 3; i++) begin
      wr_reg(4'h8, {14'h0004, pol[i], 1'b1});
      act <= !pol[i];
      width <= w[i];
      wr_reg(4'h3, 16'h0002);
      wr_reg(4'h0, 16'h0003);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait_for(1'b1, !pol[i], n);
      wait_for(1'b1, pol[i], n);
      rd_reg(4'h4, cap);
      rd_reg(4'h7, v);
      chk(v[0], w[i] > 20'h0FFFF);
      chk(n[19:0], {4'h0, cap} + 20'h00001 + {3'h0, v[0], 16'h0000});
      wr_reg(4'h0, 16'h000C);
    end
  endtask

  // Software starts with two delays, then stop and output control
  task automatic t_delay_stop();
    for (int i = 0; i < 2; i++) begin
      wr_reg(4'h3, i ? 16'h0009 : 16'h0001);
      wr_reg(4'h0, 16'h0003);
      rd_reg(4'h0, v); chk(v[1:0], 2'h3);
      wr_reg(4'h0, 16'h0001);
      wait_for(1'b0, 1'b1, nd[i]);
      rd_reg(4'h5, v); chk(v, 16'hFFFF);
      wr_reg(4'h0, 16'h000C);
    end
    chk(20'(nd[1] - nd[0]), 20'd8);
    rd_reg(4'h0, v); chk(v[1:0], 2'h0);
    chk(pin, 1'b1);
    wr_reg(4'h8, 16'h0015);
    wr_reg(4'h8, 16'h0011);
    repeat (3) @(posedge clk);
    chk(pin, 1'b1);
    wr_reg(4'h8, 16'h0034);
    repeat (3) @(posedge clk);
    chk({pin, mpin}, 2'h3);
    wr_reg(4'h8, 16'h0010);
    repeat (3) @(posedge clk);
    chk({pin, mpin}, 2'h0);
    wr_reg(4'hA, 16'h0000);
    wr_reg(4'hA, 16'h0001);
    rd_reg(4'h8, v); chk(v, 0);
  endtask

  // Clock b at half rate, both end edges, activation after one count clock
  task automatic t_prescaled();
    wr_reg(4'h9, 16'h0010);
    wr_reg(4'h1, 16'h0005);
    wr_reg(4'h2, 16'h0002);
    rd_reg(4'h2, v);
    chk(v, 16'h0006);
    wr_reg(4'h3, 16'h0002);
    wr_reg(4'h8, 16'h0011);
    act <= 1'b1;
    width <= 20'd10;
    wr_reg(4'h0, 16'h0003);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_for(1'b0, 1'b1, n);
    wait_for(1'b1, 1'b1, n);
    // Output flop plus one count clock of two clk
    chk(n[19:0], 20'd3);
    wait_for(1'b1, 1'b0, n);
    rd_reg(4'h7, v);
    chk(v, 16'h0000);
    wr_reg(4'h0, 16'h000C);
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {wr, rd, go, act} = 4'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    width = 20'h00000;
    error_cnt = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_access();
    t_pulses();
    t_delay_stop();
    t_prescaled();
    end_sim();
  end
endmodule // two_input_one_shot_pulse_timer_test

`default_nettype wire
